// File: hdl/igp_protect.sv
// Purpose: gate enable gating with undervoltage and short-circuit protection
// Assumes: all inputs synchronous to sys_clk; detectors are levels
// Notes: fault_out_n is open drain, oe low means pin pulled low
module igp_protect #(
	parameter int FAULT_CYC = igp_pkg::FAULT_PULSE_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire igp_pkg::igp_cmd_t cmd,
	input wire logic low_supply_uv_detect,
	input wire logic [2:0] high_bias_uv_detect,
	input wire logic short_circuit_trigger,
	output igp_pkg::igp_gate_t gate,
	output logic fault_out_n_o,
	output logic fault_out_n_oe
);

	// ----------------------------------------
	// edge detection and arming
	// ----------------------------------------
	logic [2:0] hi_prev;
	logic [2:0] lo_prev;
	logic [2:0] hi_arm;
	logic [2:0] lo_arm;
	logic [2:0] hi_rise;
	logic [2:0] lo_rise;
	logic [2:0] hi_block;
	logic lo_block;
	igp_pkg::igp_state_t state;
	logic [igp_pkg::FCNT_W-1:0] fcnt;
	logic fault_start;

	// commands are active high, a rise requests conduction
	// no pulse filter: short pulses pass unfiltered, honouring them is optional
	assign hi_rise = cmd.high_side_cmd & ~hi_prev;
	assign lo_rise = cmd.low_side_cmd & ~lo_prev;
	assign hi_block = high_bias_uv_detect;
	// short circuit blocks in the same cycle, before any flop
	assign lo_block = low_supply_uv_detect | short_circuit_trigger
		| (state == igp_pkg::IGP_FAULT);
	assign fault_start = low_supply_uv_detect | short_circuit_trigger;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			hi_prev <= 3'h7;
			lo_prev <= 3'h7;
		end else begin
			hi_prev <= cmd.high_side_cmd;
			lo_prev <= cmd.low_side_cmd;
		end
	end

	// reset starts with prev high so a held command cannot conduct
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			hi_arm <= igp_pkg::GATES_OFF;
			lo_arm <= igp_pkg::GATES_OFF;
		end else begin
			hi_arm <= (hi_arm | hi_rise) & cmd.high_side_cmd & ~hi_block;
			if (lo_block)
				lo_arm <= igp_pkg::GATES_OFF;
			else
				lo_arm <= (lo_arm | lo_rise) & cmd.low_side_cmd;
		end
	end

	// ----------------------------------------
	// fault pulse
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			state <= igp_pkg::IGP_RUN;
			fcnt <= '0;
		end else begin
			unique case (state)
			igp_pkg::IGP_RUN: begin
				if (fault_start) begin
					state <= igp_pkg::IGP_FAULT;
					fcnt <= igp_pkg::FCNT_W'(FAULT_CYC - 1);
				end
			end
			igp_pkg::IGP_FAULT: begin
				// fixed width: retriggers do not stretch the pulse
				if (fcnt == '0)
					state <= igp_pkg::IGP_RUN;
				else
					fcnt <= fcnt - 1'b1;
			end
			default: state <= igp_pkg::IGP_RUN;
			endcase
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign gate.high_gate = hi_arm & ~hi_block;
	assign gate.low_gate = lo_arm & {3{~lo_block}};
	assign fault_out_n_o = 1'b0;
	assign fault_out_n_oe = ~(state == igp_pkg::IGP_FAULT);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_low_uv_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
		low_supply_uv_detect |-> gate.low_gate == 3'h0)
		else $error("low side on during low supply uv");
	a_short_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
		short_circuit_trigger |-> gate.low_gate == 3'h0)
		else $error("low side on during short circuit");
	a_fault_start: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(state == igp_pkg::IGP_RUN && fault_start) |=> !fault_out_n_oe)
		else $error("fault pulse did not start");
	a_fault_low_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!fault_out_n_oe |-> gate.low_gate == 3'h0)
		else $error("low side on during fault pulse");
	a_high_uv_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
		high_bias_uv_detect[0] |-> !gate.high_gate[0])
		else $error("high switch on during bias uv");
	a_high_no_fault: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(state == igp_pkg::IGP_RUN && !fault_start) |=> fault_out_n_oe)
		else $error("fault asserted without cause");
	a_low_rearm: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(!lo_arm[0] && !lo_rise[0]) |=> !lo_arm[0])
		else $error("low side rearmed without edge");
	a_low_rearm1: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(!lo_arm[1] && !lo_rise[1]) |=> !lo_arm[1])
		else $error("low side rearmed without edge");
	a_low_rearm2: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(!lo_arm[2] && !lo_rise[2]) |=> !lo_arm[2])
		else $error("low side rearmed without edge");

	// high side: bias recovery alone must never turn a switch back on
	a_high_rearm0: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(!hi_arm[0] && !hi_rise[0]) |=> !hi_arm[0])
		else $error("high side rearmed without edge");
	a_high_rearm1: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(!hi_arm[1] && !hi_rise[1]) |=> !hi_arm[1])
		else $error("high side rearmed without edge");
	a_high_rearm2: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(!hi_arm[2] && !hi_rise[2]) |=> !hi_arm[2])
		else $error("high side rearmed without edge");
	a_high_uv1: assert property (@(posedge sys_clk) disable iff (!rst_b)
		high_bias_uv_detect[1] |-> !gate.high_gate[1])
		else $error("high switch on during bias uv");
	a_high_uv2: assert property (@(posedge sys_clk) disable iff (!rst_b)
		high_bias_uv_detect[2] |-> !gate.high_gate[2])
		else $error("high switch on during bias uv");
	a_bias_no_fault: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(state == igp_pkg::IGP_RUN && !low_supply_uv_detect
		&& !short_circuit_trigger && |high_bias_uv_detect)
		|=> fault_out_n_oe)
		else $error("fault pulse on high bias uv");

	// a low command must take the gate down at the next edge
	a_low_cmd_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
		cmd.low_side_cmd == 3'h0 |=> gate.low_gate == 3'h0)
		else $error("low gate on with command low");
	a_high_cmd_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
		cmd.high_side_cmd == 3'h0 |=> gate.high_gate == 3'h0)
		else $error("high gate on with command low");
	a_low_arm_edge: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(lo_rise[0] && !lo_block) |=> lo_arm[0])
		else $error("low side ignored rising command");
	a_reset_oe: assert property (@(posedge sys_clk)
		!rst_b |=> fault_out_n_oe)
		else $error("fault pulse during reset");
	a_rearm_edge: assert property (@(posedge sys_clk) disable iff (!rst_b)
		$rose(lo_arm[0]) |-> $past(!cmd.low_side_cmd[0]) ||
		$past(lo_prev[0]) == 1'b0)
		else $error("low side armed without rising edge");
	a_reset_off: assert property (@(posedge sys_clk)
		!rst_b |=> gate == '0)
		else $error("gates on after reset");
	a_pulse_width: assert property (@(posedge sys_clk) disable iff (!rst_b)
		$fell(fault_out_n_oe) |-> !fault_out_n_oe [*8])
		else $error("fault pulse too short");

	// ----------------------------------------
	// pulse width monitor
	// ----------------------------------------
	// a repetition of thousands of cycles would not unroll, so the low
	// cycles of the enable are counted and the total checked at its end
	logic [igp_pkg::FCNT_W-1:0] low_run;

	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			low_run <= '0;
		else if (!fault_out_n_oe)
			low_run <= low_run + 1'b1;
		else
			low_run <= '0;
	end

	a_pulse_full: assert property (@(posedge sys_clk) disable iff (!rst_b)
		$rose(fault_out_n_oe) |-> low_run == igp_pkg::FCNT_W'(FAULT_CYC))
		else $error("fault pulse width wrong");
	a_pulse_max: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!fault_out_n_oe |-> low_run < igp_pkg::FCNT_W'(FAULT_CYC))
		else $error("fault pulse stretched");

endmodule

// File: hdl/igp_pkg.sv
// Purpose: shared constants and carriers for the inverter gate protection
// Assumes: 125 MHz system clock
// Notes: one entry per phase, index 0..2 = u, v, w
package igp_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_MHZ = 125;
	// fault pulse of at least 50 us
	localparam int FAULT_PULSE_US = 50;
	localparam int FAULT_PULSE_CYC = FAULT_PULSE_US * CLK_MHZ;
	localparam int MIN_PULSE_NS = 2000;
	localparam int CLK_NS = 8;
	localparam int MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int FCNT_W = 20;
	localparam logic [2:0] GATES_OFF = 3'h0;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic [2:0] high_side_cmd;
		logic [2:0] low_side_cmd;
	} igp_cmd_t;

	typedef struct packed {
		logic [2:0] high_gate;
		logic [2:0] low_gate;
	} igp_gate_t;

	typedef enum logic [1:0] {
		IGP_RUN = 2'b00,
		IGP_FAULT = 2'b01
	} igp_state_t;

endpackage

// File: sim/igp_ctl.sv
// Purpose: controller model driving the six switch commands
// Assumes: requests may change any time; commands change on falling edges
// Notes: a phase never jumps from one side to the other directly
module igp_ctl (
	input wire logic sys_clk,
	input wire logic [5:0] req,
	output igp_pkg::igp_cmd_t cmd
);
	timeunit 1ns;
	timeprecision 1ps;
	int hold [3];
	initial cmd = '0;
	always @(negedge sys_clk) begin
		for (int i = 0; i < 3; i++) begin
			if (hold[i] > 0) begin
				hold[i]--;
			end else if ({req[i+3], req[i]} !=
				{cmd.high_side_cmd[i], cmd.low_side_cmd[i]}) begin
				// pass through off so the phase gets blanking time
				if (cmd.high_side_cmd[i] | cmd.low_side_cmd[i] |
					(req[i+3] & req[i])) begin
					cmd.high_side_cmd[i] = 1'b0;
					cmd.low_side_cmd[i] = 1'b0;
				end else begin
					cmd.high_side_cmd[i] = req[i+3];
					cmd.low_side_cmd[i] = req[i];
				end
				hold[i] = igp_pkg::MIN_PULSE_CYC;
			end
		end
	end
endmodule

// File: sim/inverter_gate_protection_logic_tb.sv
// Purpose: random self-check of the protection block against a model
// Assumes: fault pulse shortened to 20 cycles
// Notes: faults are short random pulses; checks run every cycle
module inverter_gate_protection_logic_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int FC = 20;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [5:0] req = 6'h07;
	logic lsuv = 1'b0;
	logic sct = 1'b0;
	logic [2:0] hbuv = 3'h0;
	logic fo_o, fo_oe;
	igp_pkg::igp_cmd_t cmd;
	igp_pkg::igp_gate_t gate;
	int errors = 0, n_checks = 0, cyc = 0, fcnt = 0;
	int arm [6], prev [6];
	always #4 sys_clk = ~sys_clk;
	igp_ctl u_ctl (.sys_clk(sys_clk), .req(req), .cmd(cmd));
	igp_protect #(.FAULT_CYC(FC)) u_dut (.sys_clk(sys_clk), .rst_b(rst_b),
		.cmd(cmd), .low_supply_uv_detect(lsuv), .high_bias_uv_detect(hbuv),
		.short_circuit_trigger(sct), .gate(gate), .fault_out_n_o(fo_o),
		.fault_out_n_oe(fo_oe));
	// ----------------------------------------
	// checking
	// ----------------------------------------
	task automatic chk(string what, logic [5:0] exp, logic [5:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic step;
		logic [5:0] c, eg;
		logic b;
		@(posedge sys_clk);
		c = cmd;
		for (int j = 0; j < 6; j++) begin
			b = (j < 3) ? (lsuv | sct | fcnt > 0) : hbuv[j-3];
			if (!rst_b || b || !c[j])
				arm[j] = 0;
			else if (!prev[j])
				arm[j] = 1;
			prev[j] = c[j];
			eg[j] = arm[j] && !((j < 3) ? (lsuv | sct) : hbuv[j-3]);
		end
		// the pulse is not stretched by triggers seen inside it
		fcnt = !rst_b ? 0 : fcnt > 0 ? fcnt - 1 : (lsuv | sct) ? FC : 0;
		#2;
		chk("gate", eg, gate);
		chk("fault_oe", 6'(fcnt == 0), 6'(fo_oe));
		chk("fault_o", 6'h00, 6'(fo_o));
		if (++cyc > 12000) begin
			errors++;
			end_of_test;
		end
		@(negedge sys_clk);
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'h760e));
		repeat (5) step;
		rst_b = 1'b1;
		for (int t = 0; t < 60; t++) begin
			req = 6'($urandom);
			repeat (150) begin
				lsuv = ($urandom % 90) == 0;
				sct = ($urandom % 70) == 0;
				hbuv = ($urandom % 40 == 0) ? 3'($urandom) : 3'h0;
				step;
			end
			$display("test %0d done", t);
		end
		end_of_test;
	end
endmodule
